// File: src/tgs_pkg.sv
// Package with addresses, bit positions, reset values and carriers for the timer global sync block.
package tgs_pkg;

  // Special-function register addresses.
  localparam logic [7:0] TGS_ADDR_PULSE = 8'h95;
  localparam logic [7:0] TGS_ADDR_RCAP_LOW = 8'hCA;
  localparam logic [7:0] TGS_ADDR_RCAP_HIGH = 8'hCB;
  localparam logic [7:0] TGS_ADDR_COUNT_LOW = 8'hCC;
  localparam logic [7:0] TGS_ADDR_COUNT_HIGH = 8'hCD;

  // Register pages that select the three pulse registers and the Timer 3 bytes.
  localparam logic [3:0] TGS_PAGE_RUN_START = 4'h1;
  localparam logic [3:0] TGS_PAGE_RELOAD = 4'h2;
  localparam logic [3:0] TGS_PAGE_STOP = 4'h3;
  localparam logic [3:0] TGS_PAGE_TIMER3 = 4'h1;

  // Bit positions inside each pulse register.
  localparam int TGS_BIT_TIMER0 = 0;
  localparam int TGS_BIT_TIMER1 = 1;
  localparam int TGS_BIT_TIMER2 = 2;
  localparam int TGS_BIT_TIMER3 = 3;
  localparam int TGS_BIT_TIMER2_LOW = 5;
  localparam int TGS_BIT_TIMER3_LOW = 6;

  // Writable bit mask; bits 7 and 4 are reserved.
  localparam logic [7:0] TGS_PULSE_MASK = 8'h6F;

  // Reset values.
  localparam logic [7:0] TGS_RESET_BYTE = 8'h00;
  localparam logic [3:0] TGS_RESET_RUN = 4'h0;
  localparam logic [1:0] TGS_RESET_RUN_LOW = 2'h0;

  // Timer mode code that selects capture mode.
  localparam logic [2:0] TGS_MODE_CAPTURE = 3'b010;

  // Register bus request as seen by the block.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tgs_bus_t;

  // Hardware run-flag updates from the timers: set and clear requests.
  typedef struct packed {
    logic [3:0] run_set;
    logic [3:0] run_clr;
    logic [1:0] low_set;
    logic [1:0] low_clr;
  } tgs_hw_run_t;

  // Forced reload strobes to each timer half.
  typedef struct packed {
    logic [3:0] full;
    logic [1:0] low;
  } tgs_reload_t;

  // Timer 3 count and reload bytes.
  typedef struct packed {
    logic [7:0] count_low;
    logic [7:0] count_high;
    logic [7:0] rcap_low;
    logic [7:0] rcap_high;
  } tgs_t3_regs_t;

endpackage : tgs_pkg

// File: src/tgs_pulse_decode.sv
// Decoder that turns one bus write into the self-clearing pulse strobes of the three pulse registers.
`timescale 1ns/100ps
module tgs_pulse_decode
  import tgs_pkg::*;
(
  // Register bus request.
  input wire tgs_bus_t i_bus,
  // Pulses for run start, forced reload and stop.
  output logic [7:0] o_start,
  output logic [7:0] o_reload,
  output logic [7:0] o_stop
);

  // Shared address match; the page picks which pulse register is meant.
  function automatic logic hit(input tgs_bus_t b, input logic [3:0] page);
    hit = b.wr && (b.addr == TGS_ADDR_PULSE) && (b.page == page);
  endfunction : hit

  // Only the written cycle carries a one; reserved bits are masked off.
  always_comb
  begin
    o_start = hit(i_bus, TGS_PAGE_RUN_START) ? (i_bus.wdata & TGS_PULSE_MASK) : 8'h00;
    o_reload = hit(i_bus, TGS_PAGE_RELOAD) ? (i_bus.wdata & TGS_PULSE_MASK) : 8'h00;
    o_stop = hit(i_bus, TGS_PAGE_STOP) ? (i_bus.wdata & TGS_PULSE_MASK) : 8'h00;
  end

endmodule : tgs_pulse_decode

// File: src/tgs_timer_global_sync.sv
// Timer global sync block: pulse registers, run flags, forced reloads and Timer 3 bytes.
`timescale 1ns/100ps
// Function
// - Several start bits in one write start all chosen timers on one edge.
// - Every start bit clears itself after a written one; never held.
// - Start bits 6 and 5 set Timer 3 and Timer 2 low-half run flags in split.
// - Start bits 3 to 0 set run flags of Timers 3, 2, 1, 0.
// - Reload bits 6 and 5 force low-half reloads of Timers 3 and 2 in split.
// - Reload bits 3, 2 reload both bytes unsplit, high byte only when split.
// - Forced full reload of Timer 2 or 3 is ignored in capture mode.
// - Reload bits 1 and 0 force 16-bit reload of Timer 1 and Timer 0.
// - Reload and stop bits clear themselves; writing zero does nothing.
// - Stop bits 6 and 5 clear Timer 3 and Timer 2 low-half run flags in split.
// - Stop bits 3 to 0 clear run flags of Timers 3, 2, 1, 0.
// - Timer 3 count bytes at 0xCC and 0xCD on page 1, reset zero.
// - Timer 3 reload bytes at 0xCA and 0xCB on page 1, reset zero.
// - In Timer 3 split mode main run flag drives high byte only.
// - Mode code 010 is capture mode, where forced full reloads of Timers 2 and 3 are ignored.
module tgs_timer_global_sync
  import tgs_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Register bus.
  input wire tgs_bus_t i_bus,
  output logic [7:0] o_rdata,
  // Timer configuration from the timer mode logic.
  input wire logic [1:0] i_split,
  input wire logic [2:0] i_mode_timer2,
  input wire logic [2:0] i_mode_timer3,
  // Hardware run-flag updates and Timer 3 counter updates.
  input wire tgs_hw_run_t i_hw_run,
  input wire logic i_t3_count_load,
  input wire logic [15:0] i_t3_count_value,
  // Run flags and reload strobes to the timers.
  output logic [3:0] o_run_flag,
  output logic [1:0] o_run_flag_low,
  output logic o_t3_high_run,
  output tgs_reload_t o_reload,
  output tgs_t3_regs_t o_t3_regs
);

  // Whole state of the block.
  typedef struct packed {
    logic [3:0] run;
    logic [1:0] run_low;
    tgs_reload_t reload;
    tgs_t3_regs_t t3;
    logic [7:0] rdata;
    logic t3_high_run;
  } tgs_state_t;

  tgs_state_t state_q;
  tgs_state_t state_d;
  logic [7:0] start_pulse;
  logic [7:0] reload_pulse;
  logic [7:0] stop_pulse;
  logic [1:0] capture;

  // Pulses exist only for the written cycle, so no storage holds a level.
  tgs_pulse_decode tgs_pulse_decode_inst
  (
    .i_bus(i_bus),
    .o_start(start_pulse),
    .o_reload(reload_pulse),
    .o_stop(stop_pulse)
  );

  // Capture mode for Timers 2 and 3 blocks forced full reloads.
  assign capture[0] = (i_mode_timer2 == TGS_MODE_CAPTURE);
  assign capture[1] = (i_mode_timer3 == TGS_MODE_CAPTURE);

  // Next-state logic; software pulses are applied last so they win over hardware.
  always_comb
  begin
    state_d = state_q;
    state_d.run = (state_q.run | i_hw_run.run_set) & ~i_hw_run.run_clr;
    state_d.run_low = (state_q.run_low | i_hw_run.low_set) & ~i_hw_run.low_clr;
    // All selected flags change in the same edge since one write carries them all.
    for (int i = 0; i < 4; i++)
    begin
      if (start_pulse[i])
      begin
        state_d.run[i] = 1'b1;
      end
      if (stop_pulse[i])
      begin
        state_d.run[i] = 1'b0;
      end
    end
    // Low halves respond only while their timer is split.
    for (int j = 0; j < 2; j++)
    begin
      if (start_pulse[TGS_BIT_TIMER2_LOW + j] && i_split[j])
      begin
        state_d.run_low[j] = 1'b1;
      end
      if (stop_pulse[TGS_BIT_TIMER2_LOW + j] && i_split[j])
      begin
        state_d.run_low[j] = 1'b0;
      end
      state_d.reload.low[j] = reload_pulse[TGS_BIT_TIMER2_LOW + j] && i_split[j];
      state_d.reload.full[TGS_BIT_TIMER2 + j] = reload_pulse[TGS_BIT_TIMER2 + j] && !capture[j];
    end
    state_d.reload.full[TGS_BIT_TIMER0] = reload_pulse[TGS_BIT_TIMER0];
    state_d.reload.full[TGS_BIT_TIMER1] = reload_pulse[TGS_BIT_TIMER1];
    // In split mode the main flag only runs the high byte; otherwise it runs both.
    state_d.t3_high_run = state_d.run[TGS_BIT_TIMER3];
    // Timer 3 counter updates from the counting logic, then software writes on top.
    if (i_t3_count_load)
    begin
      state_d.t3.count_low = i_t3_count_value[7:0];
      state_d.t3.count_high = i_t3_count_value[15:8];
    end
    if (i_bus.wr && i_bus.page == TGS_PAGE_TIMER3)
    begin
      unique case (i_bus.addr)
        TGS_ADDR_COUNT_LOW: state_d.t3.count_low = i_bus.wdata;
        TGS_ADDR_COUNT_HIGH: state_d.t3.count_high = i_bus.wdata;
        TGS_ADDR_RCAP_LOW: state_d.t3.rcap_low = i_bus.wdata;
        TGS_ADDR_RCAP_HIGH: state_d.t3.rcap_high = i_bus.wdata;
        default: ;
      endcase
    end
    // Pulse registers always read zero because their bits never hold.
    state_d.rdata = TGS_RESET_BYTE;
    if (i_bus.rd && i_bus.page == TGS_PAGE_TIMER3)
    begin
      unique case (i_bus.addr)
        TGS_ADDR_COUNT_LOW: state_d.rdata = state_q.t3.count_low;
        TGS_ADDR_COUNT_HIGH: state_d.rdata = state_q.t3.count_high;
        TGS_ADDR_RCAP_LOW: state_d.rdata = state_q.t3.rcap_low;
        TGS_ADDR_RCAP_HIGH: state_d.rdata = state_q.t3.rcap_high;
        default: ;
      endcase
    end
  end

  // State register with synchronous reset to zero.
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Outputs come straight from the state flip-flops.
  assign o_rdata = state_q.rdata;
  assign o_run_flag = state_q.run;
  assign o_run_flag_low = state_q.run_low;
  assign o_t3_high_run = state_q.t3_high_run;
  assign o_reload = state_q.reload;
  assign o_t3_regs = state_q.t3;

endmodule : tgs_timer_global_sync

// File: verification/tgs_timer_global_sync_assertions.sv
// Concurrent checks on the ports of the timer global sync block.
`timescale 1ns/100ps
module tgs_sync_checker
  import tgs_pkg::*;
(
  // Clock, reset and inputs.
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire tgs_bus_t i_bus,
  input wire logic [1:0] i_split,
  input wire logic [2:0] i_mode_timer3,
  // Observed outputs.
  input wire logic [3:0] o_run_flag,
  input wire logic [1:0] o_run_flag_low,
  input wire logic o_t3_high_run,
  input wire tgs_reload_t o_reload,
  input wire tgs_t3_regs_t o_t3_regs
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  // Decoded writes; only the page tells the three pulse registers apart.
  wire logic wp = i_bus.wr && i_bus.addr == TGS_ADDR_PULSE;
  wire logic run_wr = wp && i_bus.page == TGS_PAGE_RUN_START;
  wire logic stp_wr = wp && i_bus.page == TGS_PAGE_STOP;
  wire logic rld_wr = wp && i_bus.page == TGS_PAGE_RELOAD;
  wire logic cap3 = i_mode_timer3 == TGS_MODE_CAPTURE;
  wire logic [1:0] rld01 = {2{rld_wr}} & i_bus.wdata[1:0];
  sequence s_rld_low3;
    rld_wr && i_bus.wdata[6] && i_split[1];
  endsequence
  sequence s_quiet;
    !rld_wr;
  endsequence
  a_start_sets_all:
    assert property (run_wr |=> (o_run_flag & $past(i_bus.wdata[3:0])) == $past(i_bus.wdata[3:0]))
    else $error("start write left a run flag clear");
  a_stop_clears_all:
    assert property (stp_wr |=> (o_run_flag & $past(i_bus.wdata[3:0])) == 4'h0) else $error("stop write missed");
  a_low_start:
    assert property (run_wr && i_bus.wdata[6] && i_split[1] |=> o_run_flag_low[1]) else $error("low start missed");
  a_low_stop:
    assert property (stp_wr && i_bus.wdata[5] && i_split[0] |=> !o_run_flag_low[0]) else $error("low stop missed");
  a_reload_pulse_exact:
    assert property (o_reload.full[1:0] == $past(rld01)) else $error("reload strobe wrong");
  a_capture_blocks:
    assert property (rld_wr && i_bus.wdata[3] && cap3 |=> !o_reload.full[3]) else $error("reload in capture");
  a_reload_t3:
    assert property (rld_wr && i_bus.wdata[3] && !cap3 |=> o_reload.full[3]) else $error("reload t3 missed");
  a_low_reload_once:
    assert property (s_rld_low3 ##1 s_quiet |-> o_reload.low[1] ##1 !o_reload.low[1]) else $error("low reload shape");
  a_high_run_follows:
    assert property (o_t3_high_run == o_run_flag[3]) else $error("high byte run differs");
  a_count_write:
    assert property (i_bus.wr && i_bus.page == TGS_PAGE_TIMER3 && i_bus.addr == TGS_ADDR_COUNT_LOW
      |=> o_t3_regs.count_low == $past(i_bus.wdata)) else $error("count low write lost");
endmodule : tgs_sync_checker

bind tgs_timer_global_sync tgs_sync_checker tgs_sync_checker_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_bus(i_bus), .i_split(i_split), .i_mode_timer3(i_mode_timer3), .o_run_flag(o_run_flag),
  .o_run_flag_low(o_run_flag_low), .o_t3_high_run(o_t3_high_run), .o_reload(o_reload), .o_t3_regs(o_t3_regs));

// File: verification/tb_tgs_timer_global_sync.sv
// Self-checking testbench for the timer global sync block.
`timescale 1ns/100ps
module tb_tgs_timer_global_sync
  import tgs_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  tgs_bus_t i_bus = '0;
  logic [1:0] i_split = 2'h0;
  logic [2:0] i_mode_timer2 = 3'h0;
  logic [2:0] i_mode_timer3 = 3'h0;
  tgs_hw_run_t i_hw_run = '0;
  logic [7:0] o_rdata;
  logic [3:0] o_run_flag;
  logic [1:0] o_run_flag_low;
  logic o_t3_high_run;
  tgs_reload_t o_reload;
  tgs_t3_regs_t o_t3_regs;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  tgs_timer_global_sync tgs_timer_global_sync_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_bus(i_bus),
    .o_rdata(o_rdata), .i_split(i_split), .i_mode_timer2(i_mode_timer2), .i_mode_timer3(i_mode_timer3),
    .i_hw_run(i_hw_run), .i_t3_count_load(1'b0), .i_t3_count_value(16'h0000), .o_run_flag(o_run_flag),
    .o_run_flag_low(o_run_flag_low), .o_t3_high_run(o_t3_high_run), .o_reload(o_reload), .o_t3_regs(o_t3_regs));
  // Free-running clock.
  initial
  begin
    forever #5 i_clk = ~i_clk;
  end
  // Cut a hang short; the whole run needs well under a hundred cycles.
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 1000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One bus cycle; returns once the taking edge's updates have landed.
  task automatic bus(input logic rd, input logic [3:0] page, input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clk);
    i_bus <= '{wr: !rd, rd: rd, page: page, addr: addr, wdata: data};
    @(posedge i_clk);
    i_bus <= '0;
    #1;
  endtask : bus
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    bus(1'b1, TGS_PAGE_TIMER3, addr, 8'h00);
    chk("rdata", 16'(exp), 16'(o_rdata));
  endtask : rd_chk
  task automatic t_start_stop;
    i_split <= 2'h3;
    i_hw_run.run_clr <= 4'hF;
    bus(1'b0, TGS_PAGE_RUN_START, TGS_ADDR_PULSE, 8'h6F);
    i_hw_run <= '0;
    chk("run", 16'h000F, 16'(o_run_flag));
    chk("low", 16'h0003, 16'(o_run_flag_low));
    bus(1'b0, TGS_PAGE_STOP, TGS_ADDR_PULSE, 8'h25);
    chk("run", 16'h000A, 16'(o_run_flag));
    chk("low", 16'h0002, 16'(o_run_flag_low));
    i_split <= 2'h0;
    bus(1'b0, TGS_PAGE_RUN_START, TGS_ADDR_PULSE, 8'h20);
    chk("low", 16'h0002, 16'(o_run_flag_low));
    bus(1'b0, TGS_PAGE_RUN_START, TGS_ADDR_PULSE, 8'h00);
    chk("run", 16'h000A, 16'(o_run_flag));
    chk("high", 16'h0001, 16'(o_t3_high_run));
  endtask : t_start_stop
  task automatic t_reload;
    bus(1'b0, TGS_PAGE_RELOAD, TGS_ADDR_PULSE, 8'h6F);
    chk("full", 16'h000F, 16'(o_reload.full));
    chk("low rl", 16'h0000, 16'(o_reload.low));
    @(posedge i_clk);
    #1;
    chk("full", 16'h0000, 16'(o_reload.full));
    i_split <= 2'h3;
    bus(1'b0, TGS_PAGE_RELOAD, TGS_ADDR_PULSE, 8'h6C);
    chk("full", 16'h000C, 16'(o_reload.full));
    chk("low rl", 16'h0003, 16'(o_reload.low));
    i_mode_timer2 <= TGS_MODE_CAPTURE;
    i_mode_timer3 <= TGS_MODE_CAPTURE;
    bus(1'b0, TGS_PAGE_RELOAD, TGS_ADDR_PULSE, 8'h0F);
    chk("full", 16'h0003, 16'(o_reload.full));
    chk("run", 16'h000A, 16'(o_run_flag));
  endtask : t_reload
  task automatic t_t3regs;
    for (int i = 0; i < 4; i++)
    begin
      rd_chk(TGS_ADDR_RCAP_LOW + 8'(i), 8'h00);
      bus(1'b0, TGS_PAGE_TIMER3, TGS_ADDR_RCAP_LOW + 8'(i), 8'hA0 + 8'(i));
    end
    bus(1'b0, TGS_PAGE_RELOAD, TGS_ADDR_COUNT_LOW, 8'hFF);
    for (int i = 0; i < 4; i++)
    begin
      rd_chk(TGS_ADDR_RCAP_LOW + 8'(i), 8'hA0 + 8'(i));
    end
    rd_chk(TGS_ADDR_PULSE, 8'h00);
  endtask : t_t3regs
  task automatic tally_and_finish;
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // Reset for 20 cycles, then the scenarios in turn.
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_t3regs();
    t_start_stop();
    t_reload();
    tally_and_finish();
  end
endmodule : tb_tgs_timer_global_sync
